// ---- hw/rbwg_top.sv ----
`timescale 1ns/10ps
// Functional notes
// - reading interrupt condition snapshots its comparison copy
// - interrupt write keeps stale bits, sets inhibit
// - reading transmit state snapshots its comparison copy
// - transmit write keeps stale bits, sets inhibit
// - reading receive condition A snapshots comparison copy
// - receive A write keeps stale bits, sets inhibit
// - interrupt comparison bits mirror condition positions
// - transmit comparison fields: mode, inject, smoother, parity
// - receive A comparison bits mirror condition positions
module rbwg_top
  import rbwg_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // control bus
  input wire logic [4:0] CB_ADDR,
  input wire logic [7:0] CB_WDATA,
  input wire logic CB_RD,
  input wire logic CB_WR,
  output logic [7:0] CB_RDATA,
  // hardware events into the guarded registers
  input wire logic [7:0] IRQ_COND_SET,
  input wire logic [7:0] TX_STATE_SET,
  input wire logic [7:0] TX_STATE_CLR,
  input wire logic [7:0] RX_COND_A_SET,
  // register contents for the rest of the device
  output logic [7:0] IRQ_COND,
  output logic [7:0] TX_STATE,
  output logic [7:0] RX_COND_A,
  output logic COND_WRITE_INHIBIT
);

  // =====================================================================
  // address decode
  // =====================================================================

  // one strobe qualified by one offset
  function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] offset,
                                    input logic strobe);
    addr_hit = strobe && (addr == offset);
  endfunction

  logic [4:0] src_offset [RBWG_NUM_GUARDS];
  logic [4:0] cmp_offset [RBWG_NUM_GUARDS];
  logic [7:0] src_val [RBWG_NUM_GUARDS];
  logic [7:0] cmp_val [RBWG_NUM_GUARDS];
  logic [7:0] hw_set [RBWG_NUM_GUARDS];
  logic [7:0] hw_clr [RBWG_NUM_GUARDS];
  logic [RBWG_NUM_GUARDS-1:0] inhibit;
  logic [7:0] inhibit_set;

  // offsets per slot
  assign src_offset[RBWG_GUARD_IRQ] = RBWG_IRQ_COND_OFFSET;
  assign src_offset[RBWG_GUARD_TX] = RBWG_TX_STATE_OFFSET;
  assign src_offset[RBWG_GUARD_RXA] = RBWG_RX_COND_A_OFFSET;
  assign cmp_offset[RBWG_GUARD_IRQ] = RBWG_IRQ_CMP_OFFSET;
  assign cmp_offset[RBWG_GUARD_TX] = RBWG_TX_CMP_OFFSET;
  assign cmp_offset[RBWG_GUARD_RXA] = RBWG_RXA_CMP_OFFSET;

  // =====================================================================
  // inhibit flag routing
  // =====================================================================

  // flag on stale write to any guarded register
  // the flag is itself an interrupt condition bit, so it rides the set path
  always_comb
  begin
    inhibit_set = 8'h00;
    inhibit_set[COND_WRITE_INHIBIT_BIT] = |inhibit;
  end

  // hardware updates per slot; only transmit state is also cleared by hardware
  assign hw_set[RBWG_GUARD_IRQ] = IRQ_COND_SET | inhibit_set;
  assign hw_clr[RBWG_GUARD_IRQ] = 8'h00;
  assign hw_set[RBWG_GUARD_TX] = TX_STATE_SET;
  assign hw_clr[RBWG_GUARD_TX] = TX_STATE_CLR;
  assign hw_set[RBWG_GUARD_RXA] = RX_COND_A_SET;
  assign hw_clr[RBWG_GUARD_RXA] = 8'h00;

  // =====================================================================
  // guarded registers
  // =====================================================================

  // receive copy bit-for-bit
  // positions mirror because each copy is taken whole from its source
  genvar g;
  generate
    for (g = 0; g < RBWG_NUM_GUARDS; g++)
    begin : guard
      localparam logic [7:0] SRC_RST = (g == RBWG_GUARD_IRQ) ? RBWG_IRQ_COND_RESET :
                                       (g == RBWG_GUARD_TX) ? RBWG_TX_STATE_RESET :
                                       RBWG_RX_COND_A_RESET;
      localparam logic [7:0] CMP_RST = (g == RBWG_GUARD_IRQ) ? RBWG_IRQ_CMP_RESET :
                                       (g == RBWG_GUARD_TX) ? RBWG_TX_CMP_RESET :
                                       RBWG_RXA_CMP_RESET;
      rbwg_guard_reg #(
        .SRC_RESET(SRC_RST),
        .CMP_RESET(CMP_RST)
      ) u_guard (
        .clk(MCLK),
        .rst_n(RESETN),
        .rd_src(addr_hit(CB_ADDR, src_offset[g], CB_RD)),
        .wr_src(addr_hit(CB_ADDR, src_offset[g], CB_WR)),
        .wr_cmp(addr_hit(CB_ADDR, cmp_offset[g], CB_WR)),
        .wdata(CB_WDATA),
        .hw_set(hw_set[g]),
        .hw_clr(hw_clr[g]),
        .src(src_val[g]),
        .cmp(cmp_val[g]),
        .inhibit(inhibit[g])
      );
    end
  endgenerate

  // =====================================================================
  // read data
  // =====================================================================

  logic [7:0] next_rdata;

  // read mux; unmapped offsets answer zero
  always_comb
  begin
    next_rdata = RBWG_UNMAPPED_READ;
    for (int i = 0; i < RBWG_NUM_GUARDS; i++)
    begin
      if (CB_ADDR == src_offset[i])
        next_rdata = src_val[i];
      if (CB_ADDR == cmp_offset[i])
        next_rdata = cmp_val[i];
    end
  end

  // read data holds until the next read strobe
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      CB_RDATA <= RBWG_UNMAPPED_READ;
    else if (CB_RD)
      CB_RDATA <= next_rdata;
  end

  // =====================================================================
  // state to the device
  // =====================================================================
  // host reads first, else the write keeps stale bits
  assign IRQ_COND = src_val[RBWG_GUARD_IRQ];
  assign TX_STATE = src_val[RBWG_GUARD_TX];
  assign RX_COND_A = src_val[RBWG_GUARD_RXA];
  assign COND_WRITE_INHIBIT = src_val[RBWG_GUARD_IRQ][COND_WRITE_INHIBIT_BIT];

endmodule

// ---- hw/rbwg_pkg.sv ----
// =====================================================================
// shared constants for the read-before-write guard
// =====================================================================
package rbwg_pkg;

  localparam int RBWG_ADDR_W = 5;
  localparam int RBWG_DATA_W = 8;
  localparam int RBWG_NUM_GUARDS = 3;

  // =====================================================================
  // register offsets on the control bus
  // =====================================================================
  localparam logic [4:0] RBWG_IRQ_COND_OFFSET = 5'h02;
  localparam logic [4:0] RBWG_TX_STATE_OFFSET = 5'h04;
  localparam logic [4:0] RBWG_RX_COND_A_OFFSET = 5'h09;
  localparam logic [4:0] RBWG_IRQ_CMP_OFFSET = 5'h1A;
  localparam logic [4:0] RBWG_TX_CMP_OFFSET = 5'h1B;
  localparam logic [4:0] RBWG_RXA_CMP_OFFSET = 5'h1C;

  // =====================================================================
  // reset values
  // =====================================================================
  localparam logic [7:0] RBWG_IRQ_COND_RESET = 8'h00;
  localparam logic [7:0] RBWG_TX_STATE_RESET = 8'h00;
  localparam logic [7:0] RBWG_RX_COND_A_RESET = 8'h00;
  localparam logic [7:0] RBWG_IRQ_CMP_RESET = 8'h00;
  localparam logic [7:0] RBWG_TX_CMP_RESET = 8'h00;
  localparam logic [7:0] RBWG_RXA_CMP_RESET = 8'h00;
  localparam logic [7:0] RBWG_UNMAPPED_READ = 8'h00;

  // =====================================================================
  // interrupt condition / comparison bit positions
  // =====================================================================
  localparam int REQUEST_PARITY_ERR_BIT = 0;
  localparam int CTRLBUS_PARITY_ERR_BIT = 1;
  localparam int WRITE_REJECT_BIT = 2;
  localparam int COND_WRITE_INHIBIT_BIT = 3;
  localparam int LINK_ERROR_THRESHOLD_BIT = 4;
  localparam int RX_COND_A_BIT = 5;
  localparam int RX_COND_B_BIT = 6;
  localparam int USER_IRQ_BIT = 7;

  // =====================================================================
  // transmit state / comparison field positions
  // =====================================================================
  localparam int TX_MODE_LSB = 0;
  localparam int TX_MODE_MSB = 2;
  localparam int INJECT_CTRL_LSB = 3;
  localparam int INJECT_CTRL_MSB = 4;
  localparam int SMOOTHER_EN_BIT = 5;
  localparam int REQUEST_PARITY_EN_BIT = 6;
  localparam int TX_RESERVED_BIT = 7;

  // =====================================================================
  // receive condition a / comparison bit positions
  // =====================================================================
  localparam int NO_SIGNAL_BIT = 0;
  localparam int QUIET_LINE_BIT = 1;
  localparam int HALT_LINE_BIT = 2;
  localparam int MASTER_LINE_BIT = 3;
  localparam int NOISE_LINE_BIT = 4;
  localparam int NOISE_THRESHOLD_BIT = 5;
  localparam int LINE_CHANGE_BIT = 6;
  localparam int UNKNOWN_INVALID_LINE_BIT = 7;

  // guarded register slots
  typedef enum logic [1:0] {
    RBWG_GUARD_IRQ,
    RBWG_GUARD_TX,
    RBWG_GUARD_RXA
  } rbwg_guard_t;

endpackage

// ---- hw/rbwg_guard_reg.sv ----
`timescale 1ns/10ps
// =====================================================================
// one guarded source register with its comparison copy
// =====================================================================
module rbwg_guard_reg
  import rbwg_pkg::*;
#(
  parameter logic [7:0] SRC_RESET = 8'h00,
  parameter logic [7:0] CMP_RESET = 8'h00
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host accesses, one-cycle strobes
  input wire logic rd_src,
  input wire logic wr_src,
  input wire logic wr_cmp,
  input wire logic [7:0] wdata,
  // hardware updates of the source
  input wire logic [7:0] hw_set,
  input wire logic [7:0] hw_clr,
  // state
  output logic [7:0] src,
  output logic [7:0] cmp,
  output logic inhibit
);

  logic [7:0] mismatch;
  logic [7:0] next_src;

  // bits where the source differs from its comparison copy
  assign mismatch = src ^ cmp;

  // a write that touches a stale bit is flagged
  assign inhibit = wr_src && (mismatch != 8'h00);

  // source next value; hardware set wins over anything else
  always_comb
  begin
    next_src = src;
    if (wr_src)
    begin
      next_src = (src & mismatch) | (wdata & ~mismatch);
    end
    next_src = (next_src & ~hw_clr) | hw_set;
  end

  // source register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      src <= SRC_RESET;
    else
      src <= next_src;
  end

  // comparison copy: snapshot on read, direct host write otherwise
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cmp <= CMP_RESET;
    else if (rd_src)
      cmp <= src;  // pre-update value, so a same-cycle event stays guarded
    else if (wr_cmp)
      cmp <= wdata;
  end

endmodule

// ---- testbench/rbwg_top_props.sv ----
`timescale 1ns/10ps
// ========
// port-level checks of the guard
module rbwg_top_chk
  import rbwg_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // control bus
  input wire logic [4:0] CB_ADDR,
  input wire logic [7:0] CB_WDATA,
  input wire logic CB_RD,
  input wire logic CB_WR,
  input wire logic [7:0] CB_RDATA,
  // events and contents
  input wire logic [7:0] IRQ_COND_SET,
  input wire logic [7:0] TX_STATE_SET,
  input wire logic [7:0] TX_STATE_CLR,
  input wire logic [7:0] RX_COND_A_SET,
  input wire logic [7:0] IRQ_COND,
  input wire logic [7:0] TX_STATE,
  input wire logic [7:0] RX_COND_A,
  input wire logic COND_WRITE_INHIBIT
);
  logic [7:0] sh_i, sh_t, sh_r, d_i, d_t, d_r, ex_i, ex_t, ex_r, sel;
  logic wr_g, mis;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  // shadow copies; a source read is applied last so it beats a copy write
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sh_i <= 8'h00;
      sh_t <= 8'h00;
      sh_r <= 8'h00;
    end
    else
    begin
      if (CB_WR && CB_ADDR == RBWG_IRQ_CMP_OFFSET) sh_i <= CB_WDATA;
      if (CB_WR && CB_ADDR == RBWG_TX_CMP_OFFSET) sh_t <= CB_WDATA;
      if (CB_WR && CB_ADDR == RBWG_RXA_CMP_OFFSET) sh_r <= CB_WDATA;
      if (CB_RD && CB_ADDR == RBWG_IRQ_COND_OFFSET) sh_i <= IRQ_COND;
      if (CB_RD && CB_ADDR == RBWG_TX_STATE_OFFSET) sh_t <= TX_STATE;
      if (CB_RD && CB_ADDR == RBWG_RX_COND_A_OFFSET) sh_r <= RX_COND_A;
    end
  end
  // stale bits and the expected result of a guarded write
  assign d_i = IRQ_COND ^ sh_i;
  assign d_t = TX_STATE ^ sh_t;
  assign d_r = RX_COND_A ^ sh_r;
  assign ex_i = (IRQ_COND & d_i) | (CB_WDATA & ~d_i) | ((|d_i) ? 8'h08 : 8'h00);
  assign ex_t = (TX_STATE & d_t) | (CB_WDATA & ~d_t);
  assign ex_r = (RX_COND_A & d_r) | (CB_WDATA & ~d_r);
  assign wr_g = CB_WR && (CB_ADDR inside {5'h02, 5'h04, 5'h09});
  assign mis = (CB_ADDR == 5'h02) ? |d_i : (CB_ADDR == 5'h04) ? |d_t : |d_r;
  assign sel = (CB_ADDR == 5'h1A) ? sh_i : (CB_ADDR == 5'h1B) ? sh_t : sh_r;
  property p_rd_irq; CB_RD && CB_ADDR == 5'h02 |=> CB_RDATA == $past(IRQ_COND); endproperty
  a_rd_irq: assert property (p_rd_irq) else $error("irq read data wrong");
  property p_rd_tx; CB_RD && CB_ADDR == 5'h04 |=> CB_RDATA == $past(TX_STATE); endproperty
  a_rd_tx: assert property (p_rd_tx) else $error("tx read data wrong");
  property p_rd_cmp;
    CB_RD && CB_ADDR inside {5'h1A, 5'h1B, 5'h1C} |=> CB_RDATA == $past(sel);
  endproperty
  a_rd_cmp: assert property (p_rd_cmp) else $error("copy wrong");
  property p_irq_wr;
    CB_WR && CB_ADDR == 5'h02 && IRQ_COND_SET == 8'h00 |=> IRQ_COND == $past(ex_i);
  endproperty
  a_irq_wr: assert property (p_irq_wr) else $error("irq guarded write wrong");
  property p_tx_wr;
    CB_WR && CB_ADDR == 5'h04 && !(|(TX_STATE_SET | TX_STATE_CLR)) |=> TX_STATE == $past(ex_t);
  endproperty
  a_tx_wr: assert property (p_tx_wr) else $error("tx guarded write wrong");
  property p_rxa_wr;
    CB_WR && CB_ADDR == 5'h09 && RX_COND_A_SET == 8'h00 |=> RX_COND_A == $past(ex_r);
  endproperty
  a_rxa_wr: assert property (p_rxa_wr) else $error("rx a guarded write wrong");
  property p_flag_set;
    wr_g && mis |=> COND_WRITE_INHIBIT ##1 COND_WRITE_INHIBIT[*2];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  property p_flag_keep;
    wr_g && !mis && CB_ADDR != 5'h02 && !IRQ_COND_SET[3] |=> $stable(COND_WRITE_INHIBIT);
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("inhibit flag moved");
  c_blocked: cover property (wr_g && mis);
  c_clean: cover property (wr_g && !mis);
  c_snap: cover property (CB_RD && CB_ADDR == 5'h09);
endmodule

bind rbwg_top rbwg_top_chk rbwg_top_chk_i (.MCLK, .RESETN, .CB_ADDR, .CB_WDATA, .CB_RD, .CB_WR,
  .CB_RDATA, .IRQ_COND_SET, .TX_STATE_SET, .TX_STATE_CLR, .RX_COND_A_SET, .IRQ_COND, .TX_STATE,
  .RX_COND_A, .COND_WRITE_INHIBIT);

// ---- testbench/rbwg_host.sv ----
`timescale 1ns/10ps
// ========
// management processor on the control bus
module rbwg_host
  import rbwg_pkg::*;
(
  // clock
  input wire logic MCLK,
  // control bus
  output logic [4:0] CB_ADDR,
  output logic [7:0] CB_WDATA,
  output logic CB_RD,
  output logic CB_WR,
  input wire logic [7:0] CB_RDATA
);
  // idle bus at time zero
  initial
  begin
    CB_ADDR = 5'h00;
    CB_WDATA = 8'h00;
    CB_RD = 1'b0;
    CB_WR = 1'b0;
  end
  // one access, held to its taking edge; released lines show inverted garbage
  task automatic acc(input logic r, input logic [4:0] a, input logic [7:0] w,
                     output logic [7:0] d);
    @(posedge MCLK);
    CB_RD <= r;
    CB_WR <= !r;
    CB_ADDR <= a;
    CB_WDATA <= w;
    @(posedge MCLK);
    CB_RD <= 1'b0;
    CB_WR <= 1'b0;
    CB_ADDR <= ~a;
    CB_WDATA <= ~w;
    #1;
    d = CB_RDATA;
  endtask
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
// ========
// self-checking bench for the guard
module tb
  import rbwg_pkg::*;
;
  logic MCLK = 1'b0;
  logic RESETN = 1'b0;
  logic [4:0] CB_ADDR;
  logic [7:0] CB_WDATA, CB_RDATA, IRQ_COND, TX_STATE, RX_COND_A;
  logic CB_RD, CB_WR, COND_WRITE_INHIBIT;
  logic [7:0] IRQ_COND_SET = 8'h00, TX_STATE_SET = 8'h00, TX_STATE_CLR = 8'h00;
  logic [7:0] RX_COND_A_SET = 8'h00;
  logic [7:0] mem [3] = '{8'h00, 8'h00, 8'h00};
  logic flag_exp = 1'b0;
  int n_errors = 0, checks = 0, cycles = 0;
  localparam logic [4:0] SA [3] = '{5'h02, 5'h04, 5'h09};
  localparam logic [4:0] CA [3] = '{5'h1A, 5'h1B, 5'h1C};
  rbwg_top rbwg_top_i (.MCLK, .RESETN, .CB_ADDR, .CB_WDATA, .CB_RD, .CB_WR, .CB_RDATA,
    .IRQ_COND_SET, .TX_STATE_SET, .TX_STATE_CLR, .RX_COND_A_SET, .IRQ_COND, .TX_STATE,
    .RX_COND_A, .COND_WRITE_INHIBIT);
  rbwg_host rbwg_host_i (.MCLK, .CB_ADDR, .CB_WDATA, .CB_RD, .CB_WR, .CB_RDATA);
  // clock
  always #5 MCLK = ~MCLK;
  // hang guard, far above the roughly 150 cycles the run needs
  always @(posedge MCLK)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  function automatic logic [7:0] src(int s);
    return (s == 0) ? IRQ_COND : (s == 1) ? TX_STATE : RX_COND_A;
  endfunction
  task automatic give_verdict();
    if (n_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // write one guarded source against copy cp and judge bits and flag
  task automatic wr_chk(int s, logic [7:0] w, logic [7:0] cp);
    logic [7:0] m, d;
    m = mem[s] ^ cp;
    rbwg_host_i.acc(1'b0, SA[s], w, d);
    mem[s] = (mem[s] & m) | (w & ~m);
    if (m != 8'h00) flag_exp = 1'b1;
    else if (s == 0) flag_exp = w[3];
    mem[0][3] = flag_exp;
    `CHK(src(s), mem[s])
    `CHK(COND_WRITE_INHIBIT, flag_exp)
  endtask
  // every address reads zero after reset, unmapped writes are dropped
  task automatic t_reset();
    logic [7:0] d;
    rbwg_host_i.acc(1'b0, 5'h1F, 8'hFF, d);
    for (int a = 0; a < 32; a++)
    begin
      rbwg_host_i.acc(1'b1, 5'(a), 8'h00, d);
      `CHK(d, 8'h00)
    end
  endtask
  // snapshot, hardware event, blocked write, then read-first clean write
  task automatic t_guard(int s, logic [7:0] e, logic [7:0] c, logic [7:0] w, logic [7:0] w2);
    logic [7:0] d, cp;
    rbwg_host_i.acc(1'b1, SA[s], 8'h00, d);
    `CHK(d, mem[s])
    rbwg_host_i.acc(1'b1, CA[s], 8'h00, d);
    `CHK(d, mem[s])
    cp = mem[s];
    @(posedge MCLK);
    if (s == 0) IRQ_COND_SET <= e;
    if (s == 1) TX_STATE_SET <= e;
    if (s == 2) RX_COND_A_SET <= e;
    TX_STATE_CLR <= c;
    @(posedge MCLK);
    {IRQ_COND_SET, TX_STATE_SET, TX_STATE_CLR, RX_COND_A_SET} <= 32'h0000_0000;
    #1;
    mem[s] = (mem[s] & ~c) | e;
    `CHK(src(s), mem[s])
    wr_chk(s, w, cp);
    rbwg_host_i.acc(1'b1, SA[s], 8'h00, d);
    wr_chk(s, w2, mem[s]);
  endtask
  // copies written directly go stale against every bit
  task automatic t_cmp();
    logic [7:0] d;
    for (int s = 0; s < 3; s++)
    begin
      rbwg_host_i.acc(1'b0, CA[s], ~mem[s], d);
      rbwg_host_i.acc(1'b1, CA[s], 8'h00, d);
      `CHK(d, ~mem[s])
      wr_chk(s, 8'h55, ~mem[s]);
    end
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge MCLK);
    RESETN <= 1'b1;
    t_reset();
    t_guard(1, 8'h24, 8'h00, 8'h00, 8'h5A);
    t_guard(1, 8'h81, 8'h18, 8'hFF, 8'h3C);
    t_guard(2, 8'hA5, 8'h00, 8'h0F, 8'hC3);
    t_guard(0, 8'h81, 8'h00, 8'h00, 8'h00);
    t_cmp();
    give_verdict();
  end
endmodule
